// file: hw/startup_delay_latch_control.sv
// Start-up suppression, standstill detection and catch latching of three relays.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Delay starts at power-up and after standstill
// - Modes 1-8 give 1 to 128 seconds
// - Mode 9 holds until first set-value overstep
// - Mode 10 holds until the remote signal goes low
// - Assignment mask picks delayed relays
// - Catch mask latches relays until key/control
// - Catch 8-15 also releases on standstill
// - Standstill after programmable zero-frequency time
module startup_delay_latch_control #(
   parameter int unsigned TICK_CYCLES = startup_pkg::TICK_CYCLES
) (
   // Clock, reset, enable
   input  wire logic                             clk_i,
   input  wire logic                             rst_b_i,
   input  wire logic                             clk_en_i,
   // Configuration, same clock domain
   input  wire startup_pkg::cfg_t                cfg_i,
   // Comparison results from the same clock domain
   input  wire logic [startup_pkg::RELAYS-1:0]   compare_i,
   input  wire logic                             over_set_i,
   // Asynchronous pins
   input  wire startup_pkg::pins_t               pins_i,
   // Results
   output logic [startup_pkg::RELAYS-1:0]        relay_o,
   output logic                                  delay_active_o,
   output logic                                  standstill_o
);
   localparam int unsigned PW = $bits(startup_pkg::pins_t);

   logic                     tick;
   logic [PW-1:0]            sync1_q, sync2_q;
   startup_pkg::pins_t       pin;
   startup_pkg::phase_t      phase_q, phase_d;
   logic [startup_pkg::DELAY_W-1:0] dcnt_q, dcnt_d;
   logic [startup_pkg::STILL_W-1:0] scnt_q, scnt_d;
   logic                     still_q, still_d;
   logic [startup_pkg::RELAYS-1:0] latch_q, latch_d;
   logic [startup_pkg::RELAYS-1:0] relay_q, relay_d;
   logic                     dact_q, dact_d;
   logic [startup_pkg::DELAY_W-1:0] delay_len;
   logic                     still_rise;
   logic                     release_all;
   logic [startup_pkg::RELAYS-1:0] gated;

   tick_gen #(
      .CYCLES (TICK_CYCLES)
   ) u_tick (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .en_i    (clk_en_i),
      .tick_o  (tick)
   );

   // Pins are synchronised as one vector; only the second stage is read.
   // The stages keep sampling through reset, so that the first cycle after reset already sees the true pin levels.
   // A reset value here would read as a low remote signal and end a remote-mode delay at once.
   always_ff @(posedge clk_i) begin
      if (clk_en_i) begin
         sync1_q <= pins_i;
         sync2_q <= sync1_q;
      end
   end
   assign pin = startup_pkg::pins_t'(sync2_q);

   // Standstill: count hundredths of zero frequency up to the set time.
   always_comb begin
      scnt_d = scnt_q;
      still_d = still_q;
      if (!pin.zero_freq) begin
         scnt_d  = '0;
         still_d = 1'b0;
      end else if (!still_q) begin
         if (scnt_q >= cfg_i.still_time) begin
            still_d = 1'b1;
         end else if (tick) begin
            scnt_d = scnt_q + 1'b1;
         end
      end
   end
   assign still_rise = still_d && !still_q;

   // Fixed delay in ticks: one second doubled per mode step.
   always_comb begin
      delay_len = '0;
      if (cfg_i.startup_mode_code != startup_pkg::MODE_NONE &&
          cfg_i.startup_mode_code <= startup_pkg::MODE_FIXED_MAX) begin
         delay_len = startup_pkg::DELAY_W'(startup_pkg::TICKS_PER_SEC)
                     << (cfg_i.startup_mode_code - 4'h1);
      end
   end

   // Delay phase machine; IDLE is the trigger state after reset or standstill.
   always_comb begin
      phase_d = phase_q;
      dcnt_d  = dcnt_q;
      case (phase_q)
         startup_pkg::ST_IDLE: begin
            dcnt_d  = '0;
            phase_d = (cfg_i.startup_mode_code == startup_pkg::MODE_NONE) ?
                      startup_pkg::ST_RUN : startup_pkg::ST_DELAY;
         end
         startup_pkg::ST_DELAY: begin
            if (cfg_i.startup_mode_code == startup_pkg::MODE_SETPOINT) begin
               if (over_set_i) phase_d = startup_pkg::ST_RUN;
            end else if (cfg_i.startup_mode_code == startup_pkg::MODE_REMOTE) begin
               if (!pin.remote) phase_d = startup_pkg::ST_RUN;
            end else if (cfg_i.startup_mode_code > startup_pkg::MODE_REMOTE ||
                         cfg_i.startup_mode_code == startup_pkg::MODE_NONE) begin
               phase_d = startup_pkg::ST_RUN;
            end else if (dcnt_q >= delay_len) begin
               phase_d = startup_pkg::ST_RUN;
            end else if (tick) begin
               dcnt_d = dcnt_q + 1'b1;
            end
         end
         startup_pkg::ST_RUN: begin
            phase_d = startup_pkg::ST_RUN;
         end
         default: begin
            phase_d = startup_pkg::ST_IDLE;
         end
      endcase
      if (still_rise) begin
         phase_d = startup_pkg::ST_IDLE;
      end
   end

   // Relay path: suppression, then catch latching.
   assign release_all = pin.release_key || pin.release_ctrl ||
                        (cfg_i.catch_code[startup_pkg::CATCH_AUTO_BIT] && still_rise);
   assign dact_d = (phase_d != startup_pkg::ST_RUN);

   for (genvar i = 0; i < startup_pkg::RELAYS; i++) begin : g_relay
      always_comb begin
         gated[i] = compare_i[i] && !(dact_q && cfg_i.delay_mask[i]);
         latch_d[i] = latch_q[i];
         if (release_all) begin
            latch_d[i] = 1'b0;
         end
         if (cfg_i.catch_code[i] && gated[i]) begin
            latch_d[i] = 1'b1;
         end
         relay_d[i] = gated[i] || (latch_q[i] && cfg_i.catch_code[i]);
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         phase_q <= startup_pkg::ST_IDLE;
         dcnt_q  <= '0;
         scnt_q  <= '0;
         still_q <= 1'b0;
         latch_q <= '0;
         relay_q <= '0;
         dact_q  <= 1'b1;
      end else if (clk_en_i) begin
         phase_q <= phase_d;
         dcnt_q  <= dcnt_d;
         scnt_q  <= scnt_d;
         still_q <= still_d;
         latch_q <= latch_d;
         relay_q <= relay_d;
         dact_q  <= dact_d;
      end
   end

   assign relay_o        = relay_q;
   assign delay_active_o = dact_q;
   assign standstill_o   = still_q;
endmodule : startup_delay_latch_control
`default_nettype wire

// file: hw/startup_pkg.sv
// Package with constants and carrier types for the start-up delay and latch controller.
package startup_pkg;

   localparam int unsigned CLK_HZ          = 125_000_000;
   localparam int unsigned TICK_PERIOD_MS  = 10;
   localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_PERIOD_MS;
   localparam int unsigned TICKS_PER_SEC   = 1000 / TICK_PERIOD_MS;

   localparam int unsigned RELAYS          = 3;
   localparam logic [3:0]  MODE_NONE       = 4'h0;
   localparam logic [3:0]  MODE_FIXED_MAX  = 4'h8;
   localparam logic [3:0]  MODE_SETPOINT   = 4'h9;
   localparam logic [3:0]  MODE_REMOTE     = 4'hA;
   localparam int unsigned CATCH_AUTO_BIT  = 3;
   localparam int unsigned STILL_W         = 14;
   localparam int unsigned DELAY_W         = 15;

   typedef struct packed {
      logic [3:0]         startup_mode_code;
      logic [RELAYS-1:0]  delay_mask;
      logic [3:0]         catch_code;
      logic [STILL_W-1:0] still_time;
   } cfg_t;

   typedef struct packed {
      logic               remote;
      logic               release_key;
      logic               release_ctrl;
      logic               zero_freq;
   } pins_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_DELAY = 2'b01,
      ST_RUN   = 2'b11
   } phase_t;

endpackage : startup_pkg

// file: hw/tick_gen.sv
// Free-running divider that emits the hundredth-second tick.
`timescale 1ns/1ps
`default_nettype none
module tick_gen #(
   parameter int unsigned CYCLES = startup_pkg::TICK_CYCLES
) (
   // Clock, reset and enable
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic en_i,
   // Tick
   output logic      tick_o
);
   logic [$clog2(CYCLES)-1:0] cnt_q, cnt_d;
   logic                      tick_q, tick_d;

   always_comb begin
      tick_d = 1'b0;
      cnt_d  = cnt_q + 1'b1;
      if (cnt_q == ($clog2(CYCLES))'(CYCLES - 1)) begin
         cnt_d  = '0;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else if (en_i) begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tick_o = tick_q;
endmodule : tick_gen
`default_nettype wire

// file: verification/sdlc_assertions.sv
// Port checks for the start-up delay and latch controller.
`timescale 1ns/1ps
`default_nettype none
module sdlc_chk (
   input wire logic               clk_i,
   input wire logic               rst_b_i,
   input wire logic               clk_en_i,
   input wire startup_pkg::cfg_t  cfg_i,
   input wire logic [2:0]         compare_i,
   input wire logic               over_set_i,
   input wire startup_pkg::pins_t pins_i,
   input wire logic [2:0]         relay_o,
   input wire logic               delay_active_o,
   input wire logic               standstill_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence no_rel;
      !pins_i.release_key && !pins_i.release_ctrl;
   endsequence
   a_reset_vals: assert property (disable iff (1'b0) !rst_b_i |=> relay_o == 3'h0 && delay_active_o)
      else $error("bad reset outputs");
   a_held_off: assert property ($past(delay_active_o) && $past(rst_b_i, 2) && $past(cfg_i.catch_code) == 4'h0
      |-> (relay_o & $past(cfg_i.delay_mask)) == 3'h0) else $error("delayed relay switched");
   a_pass_thru: assert property (!$past(delay_active_o) && $past(cfg_i.catch_code) == 4'h0
      |-> relay_o == $past(compare_i)) else $error("relay not following compare");
   a_zero_mode: assert property ($rose(rst_b_i) && cfg_i.startup_mode_code == 4'h0
      |-> ##[1:4] !delay_active_o) else $error("mode 0 delayed");
   a_still_restart: assert property ($rose(standstill_o) && cfg_i.startup_mode_code inside {[4'h1:4'h8]}
      |-> ##[1:3] delay_active_o) else $error("no restart on standstill");
   a_catch_hold: assert property (no_rel[*3] ##0 relay_o[0] && cfg_i.catch_code == 4'h1
      |=> relay_o[0]) else $error("latch lost");
   a_key_free: assert property ((pins_i.release_key && compare_i == 3'h0)[*4] |=> relay_o == 3'h0)
      else $error("latch not released");
   a_first_over: assert property (cfg_i.startup_mode_code == 4'h9 && over_set_i
      |-> ##[1:4] !delay_active_o) else $error("mode 9 delay not ended");
   a_remote_end: assert property ((cfg_i.startup_mode_code == 4'hA && !pins_i.remote && !standstill_o)[*6]
      |-> !delay_active_o) else $error("remote delay not ended");
endmodule : sdlc_chk
bind startup_delay_latch_control sdlc_chk chk (.*);
`default_nettype wire

// file: verification/far_side_model.sv
// Far side: operator key, control input, remote signal and zero-frequency detector.
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
   input  wire logic               clk_i,
   input  wire startup_pkg::pins_t want_i,
   output var startup_pkg::pins_t  pins_o
);
   initial pins_o = '0;
   // Pins move just after the rising edge, so the bench's falling-edge changes never race them.
   always @(posedge clk_i) begin
      pins_o <= want_i;
   end
endmodule : far_side_model
`default_nettype wire

// file: verification/startup_delay_latch_control_tb.sv
// Self-checking bench for the start-up delay and latch controller.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module startup_delay_latch_control_tb;
   localparam int TICK = 10;
   logic clk = 1'b0, rst_b = 1'b0, over = 1'b0, dly, still;
   logic [2:0] cmp = 3'h0, rel;
   startup_pkg::cfg_t cfg = '0;
   startup_pkg::pins_t want = '0, pins;
   int miscompares = 0, n_checks = 0, n, e;
   always #4 clk = ~clk;
   far_side_model peer (.clk_i(clk), .want_i(want), .pins_o(pins));
   startup_delay_latch_control #(.TICK_CYCLES(TICK)) dut (.clk_i(clk), .rst_b_i(rst_b), .clk_en_i(1'b1),
      .cfg_i(cfg), .compare_i(cmp), .over_set_i(over), .pins_i(pins), .relay_o(rel),
      .delay_active_o(dly), .standstill_o(still));
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict
   task automatic go(input logic [3:0] m, input int k);
      cfg.startup_mode_code = m;
      rst_b = 1'b0;
      repeat (8) @(negedge clk);
      rst_b = 1'b1;
      repeat (k) @(negedge clk);
   endtask : go
   task automatic wait_for(input bit s, input int lim);
      n = 0;
      while ((s ? still !== 1'b1 : dly !== 1'b0) && n < lim) begin
         @(negedge clk);
         n++;
      end
      if (n >= lim) begin
         miscompares++;
         print_verdict();
      end
   endtask : wait_for
   initial begin
      void'($urandom(83));
      for (int i = 0; i < 2; i++) begin
         cmp = 3'($urandom);
         cfg.delay_mask = 3'($urandom);
         e = i ? int'($urandom % 3) + 1 : 0;
         go(4'(e + 1), 3);
         `CHK(rel, cmp & ~cfg.delay_mask)
         wait_for(0, 9000);
         e = TICK * 100 * (1 << e) - n;
         `CHK(e >= 0 && e <= 12, 1'b1)
         @(negedge clk);
         `CHK(rel, cmp)
      end
      e = int'($urandom % 20) + 1;
      cfg.still_time = 14'(e);
      want.zero_freq = 1'b1;
      wait_for(1, 400);
      e = e * TICK - n;
      `CHK(e >= -6 && e <= TICK, 1'b1)
      repeat (3) @(negedge clk);
      `CHK(dly, 1'b1)
      want = '0;
      $display("delay and standstill tests done");
      for (int k = 0; k < 2; k++) begin
         cfg.catch_code = k ? 4'h9 : 4'h1;
         cfg.still_time = 14'h0001;
         go(4'h0, 4);
         cmp = 3'h3;
         repeat (3) @(negedge clk);
         cmp = 3'h0;
         repeat (5) @(negedge clk);
         `CHK(rel, 3'h1)
         want.zero_freq = k[0];
         want.release_key = !k[0];
         repeat (40) @(negedge clk);
         `CHK(rel, 3'h0)
         want = '0;
      end
      cfg.catch_code = 4'h0;
      go(4'h9, 50);
      `CHK(dly, 1'b1)
      over = 1'b1;
      repeat (6) @(negedge clk);
      `CHK(dly, 1'b0)
      over = 1'b0;
      want.remote = 1'b1;
      go(4'hA, 50);
      `CHK(dly, 1'b1)
      want.remote = 1'b0;
      repeat (8) @(negedge clk);
      `CHK(dly, 1'b0)
      $display("catch and mode tests done");
      print_verdict();
   end
endmodule : startup_delay_latch_control_tb
`default_nettype wire
